/* File: core/memmap_pkg.sv */
/*
 * Shared constants and carrier types for the banked memory address map:
 * register offsets, status fields, vectors, reset values and the core's request bundles.
 * Assumes one core clock and one synchronous active-low reset for every user.
 */
`default_nettype none

package memmap_pkg;

    // program side
    localparam int PROG_ADDR_BITS = 13;
    localparam int PROG_WORD_BITS = 14;
    localparam int PROG_FULL_BITS = 13;
    localparam int PROG_SMALL_BITS = 12;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // data side
    localparam int DATA_ADDR_BITS = 9;
    localparam int DATA_BITS = 8;
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PCL = 7'h02;
    localparam logic [6:0] OFS_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 7'h0a;
    localparam logic [6:0] GPR_START = 7'h20;
    localparam logic [6:0] COMMON_START = 7'h70;

    // status fields
    localparam int STATUS_IND_BANK_BIT = 7;
    localparam int STATUS_BANK_HIGH_BIT = 6;
    localparam int STATUS_BANK_LOW_BIT = 5;

    // branch target joins the high latch at these bits
    localparam int LATCH_PAGE_HIGH_BIT = 4;
    localparam int LATCH_PAGE_LOW_BIT = 3;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] PROGRAM_COUNTER_HIGH_LATCH_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    typedef enum logic [3:0] {
        phase_one = 4'b0001,
        phase_two = 4'b0010,
        phase_three = 4'b0100,
        phase_four = 4'b1000
    } phase_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] operand;
        logic [7:0] wdata;
    } data_req_type;

    typedef struct packed {
        logic irq_accept;
        logic branch;
        logic [10:0] target;
    } prog_ctl_type;

endpackage

`default_nettype wire

/* File: core/gpr_store.sv */
/*
 * Static RAM behind the general purpose register area, indexed by physical data address.
 * Assumes the caller only enables writes for locations that really hold storage.
 */
`default_nettype none

module gpr_store #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 8
) (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    // read port, combinational
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // no reset: general purpose registers power up undefined
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[rd_addr_i];

endmodule

`default_nettype wire

/* File: core/banked_memory_address_map.sv */
/*
 * Program counter and banked data address decode of a small 8-bit core, with the
 * core-held registers (pointer, status, counter low and high latch) and GPR storage.
 * Assumes the execute datapath holds its data request and program controls stable
 * for a whole four-phase instruction cycle and samples rdata_o after phase two.
 */
`default_nettype none

module banked_memory_address_map
    import memmap_pkg::*;
#(
    parameter int IMPL_ADDR_BITS = PROG_FULL_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // program control from the execute datapath
    input wire prog_ctl_type prog_i,
    // data operand request from the execute datapath
    input wire data_req_type req_i,
    // program side results
    output logic [PROG_ADDR_BITS-1:0] pc_o,
    output logic [PROG_ADDR_BITS-1:0] fetch_addr_o,
    // data side results
    output logic [DATA_BITS-1:0] rdata_o,
    output phase_type phase_o
);

    localparam logic [PROG_ADDR_BITS-1:0] PROG_MASK = PROG_ADDR_BITS'((1 << IMPL_ADDR_BITS) - 1);

    phase_type phase;
    phase_type next_phase;
    logic [PROG_ADDR_BITS-1:0] pc;
    logic [PROG_ADDR_BITS-1:0] next_pc;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [7:0] program_counter_high_latch;
    logic [DATA_BITS-1:0] rdata;

    // folds the unimplemented top of banks 1-3 onto the bank 0 common area
    function automatic logic [DATA_ADDR_BITS-1:0] fold_common(input logic [DATA_ADDR_BITS-1:0] a);
        if (a[6:0] >= COMMON_START) begin
            return {2'b00, a[6:0]};
        end
        return a;
    endfunction

    // four-phase instruction cycle sequencer
    always_comb begin
        unique case (phase)
            phase_one: next_phase = phase_two;
            phase_two: next_phase = phase_three;
            phase_three: next_phase = phase_four;
            phase_four: next_phase = phase_one;
            default: next_phase = phase_one;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase <= phase_one;
        end else begin
            phase <= next_phase;
        end
    end

    // data address formation
    wire logic [DATA_ADDR_BITS-1:0] ind_addr = {status[STATUS_IND_BANK_BIT], pointer};
    wire logic [DATA_ADDR_BITS-1:0] dir_addr =
        {status[STATUS_BANK_HIGH_BIT], status[STATUS_BANK_LOW_BIT], req_i.operand};
    wire logic use_ind = (req_i.operand == OFS_INDIRECT);
    wire logic [DATA_ADDR_BITS-1:0] log_addr = use_ind ? ind_addr : dir_addr;
    wire logic [DATA_ADDR_BITS-1:0] phys_addr = fold_common(log_addr);
    wire logic [6:0] offset = phys_addr[6:0];

    // offset decode is bank-independent, which mirrors the core registers everywhere
    wire logic hit_gpr = (offset >= GPR_START);
    wire logic hit_pcl = (offset == OFS_PCL);
    wire logic hit_status = (offset == OFS_STATUS);
    wire logic hit_pointer = (offset == OFS_POINTER);
    wire logic hit_program_counter_high_latch = (offset == OFS_PROGRAM_COUNTER_HIGH_LATCH);

    // indirect through a pointer at offset zero reads zero and writes nothing
    logic [DATA_BITS-1:0] ram_rdata;
    wire logic [DATA_BITS-1:0] rd_value =
        hit_gpr ? ram_rdata :
        hit_pcl ? pc[7:0] :
        hit_status ? status :
        hit_pointer ? pointer :
        hit_program_counter_high_latch ? program_counter_high_latch : 8'h00;

    wire logic rd_fire = (phase == phase_two) && req_i.valid;
    wire logic wr_fire = (phase == phase_four) && req_i.valid && req_i.write;
    wire logic wr_ram = wr_fire && hit_gpr;

    gpr_store #(
        .ADDR_W(DATA_ADDR_BITS),
        .DATA_W(DATA_BITS)
    ) u_gpr (
        .clk_i(clk_i),
        .wr_en_i(wr_ram),
        .wr_addr_i(phys_addr),
        .wr_data_i(req_i.wdata),
        .rd_addr_i(phys_addr),
        .rd_data_o(ram_rdata)
    );

    // operand capture
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata <= RDATA_RESET;
        end else if (rd_fire) begin
            rdata <= rd_value;
        end
    end

    // core-held registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            status <= STATUS_RESET;
            pointer <= POINTER_RESET;
            program_counter_high_latch <= PROGRAM_COUNTER_HIGH_LATCH_RESET;
        end else if (wr_fire) begin
            if (hit_status) begin
                status <= req_i.wdata;
            end
            if (hit_pointer) begin
                pointer <= req_i.wdata;
            end
            if (hit_program_counter_high_latch) begin
                program_counter_high_latch <= req_i.wdata;
            end
        end
    end

    // program counter: vector beats branch beats increment; a low-byte write loads from the latch
    always_comb begin
        next_pc = pc;
        if (phase == phase_one) begin
            if (prog_i.irq_accept) begin
                next_pc = IRQ_VECTOR;
            end else if (prog_i.branch) begin
                next_pc = {program_counter_high_latch[LATCH_PAGE_HIGH_BIT:LATCH_PAGE_LOW_BIT], prog_i.target};
            end else begin
                next_pc = PROG_ADDR_BITS'(pc + 13'h0001);
            end
        end
        if (wr_fire && hit_pcl) begin
            next_pc = {program_counter_high_latch[4:0], req_i.wdata};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pc <= RESET_VECTOR;
        end else begin
            pc <= next_pc;
        end
    end

    // the counter keeps all 13 bits; only the fetch address drops unimplemented ones
    assign fetch_addr_o = pc & PROG_MASK;
    assign pc_o = pc;
    assign rdata_o = rdata;
    assign phase_o = phase;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_reset_pc_zero: assert property ($rose(resetn_i) |-> pc == RESET_VECTOR && phase == phase_one)
        else $error("counter not at zero after reset");

    a_irq_to_vector: assert property (phase == phase_one && prog_i.irq_accept |=> pc == IRQ_VECTOR)
        else $error("interrupt did not reach vector");

    a_pc_increments: assert property (
        phase == phase_one && !prog_i.irq_accept && !prog_i.branch
        |=> pc == PROG_ADDR_BITS'($past(pc) + 13'h0001))
        else $error("counter did not step once per cycle");

    a_pc_holds_between: assert property (
        phase == phase_two && !(req_i.valid && req_i.write) |=> ##1 $stable(pc) [*2])
        else $error("counter moved outside phase one");

    a_fetch_wraps: assert property (fetch_addr_o < 14'(1 << IMPL_ADDR_BITS)
        && fetch_addr_o[IMPL_ADDR_BITS-1:0] == pc[IMPL_ADDR_BITS-1:0])
        else $error("fetch address not wrapped");

    a_direct_bank: assert property (
        req_i.valid && !use_ind && req_i.operand < COMMON_START
        |-> phys_addr[8:7] == status[6:5])
        else $error("direct bank not from status");

    a_indirect_addr: assert property (
        req_i.valid && use_ind && pointer[6:0] < COMMON_START
        |-> phys_addr == {status[7], pointer})
        else $error("indirect address wrong");

    a_common_fold: assert property (log_addr[6:0] >= COMMON_START |-> phys_addr[8:7] == 2'b00)
        else $error("common area not folded to bank zero");

    a_mirror_pointer: assert property (
        rd_fire && hit_pointer |=> rdata_o == $past(pointer))
        else $error("mirrored pointer read wrong");

    a_read_in_phase: assert property (!$stable(rdata_o) |-> $past(phase) == phase_two)
        else $error("operand captured outside phase two");

    a_write_in_phase: assert property (
        !$stable(pointer) || !$stable(status) || !$stable(program_counter_high_latch)
        |-> $past(phase) == phase_four)
        else $error("register written outside phase four");

    a_gpr_roundtrip: assert property (
        wr_ram ##1 phase == phase_one && req_i.valid && $stable(phys_addr) ##1 1'b1
        |=> rdata_o == $past(req_i.wdata, 3))
        else $error("static RAM did not return written byte");

    c_irq_taken: cover property (phase == phase_one && prog_i.irq_accept);
    c_indirect_read: cover property (rd_fire && use_ind && hit_gpr);
    c_common_write: cover property (wr_ram && log_addr[8:7] != 2'b00 && log_addr[6:0] >= COMMON_START);
    c_pcl_write: cover property (wr_fire && hit_pcl);

endmodule

`default_nettype wire

/* File: tb/core_datapath_model.sv */
/*
 * Execute datapath stand-in: presents one request and program control per instruction cycle.
 * Assumes the map's phase output starts in phase_one right after reset.
 */
`default_nettype none

module core_datapath_model
    import memmap_pkg::*;
(
    // clock and phase from the map
    input wire logic clk_i,
    input wire phase_type phase_i,
    // requests toward the map
    output data_req_type req_o,
    output prog_ctl_type prog_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int lost = 0;

    initial begin
        req_o = '0;
        prog_o = '0;
    end

    // starts before the phase_one edge and holds for four clocks, so a write lands first
    task automatic issue(input data_req_type r, input prog_ctl_type c);
        int n;
        n = 0;
        while (phase_i !== phase_one && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 8) lost++;
        // idle data lines show no stale value
        if (!r.valid) r.wdata = ~req_o.wdata;
        req_o = r;
        prog_o = c;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire

/* File: tb/test_banked_memory_address_map.sv */
/*
 * Self-checking bench for the address map, full and 4K variants fed alike.
 * Assumes the datapath model drives requests; the bench drives clock and reset.
 */
`default_nettype none

module test_banked_memory_address_map
    import memmap_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    data_req_type req;
    prog_ctl_type prog;
    logic [12:0] pc, fa, pc_s, fa_s;
    logic [7:0] rd;
    phase_type ph;
    int n_fail = 0;
    int checks_done = 0;

    always #50 clk_i = ~clk_i;

    core_datapath_model u_core_datapath_model (.clk_i(clk_i), .phase_i(ph), .req_o(req), .prog_o(prog));

    banked_memory_address_map u_banked_memory_address_map (.clk_i(clk_i), .resetn_i(resetn_i),
        .prog_i(prog), .req_i(req), .pc_o(pc), .fetch_addr_o(fa), .rdata_o(rd), .phase_o(ph));

    banked_memory_address_map #(.IMPL_ADDR_BITS(12)) u_banked_memory_address_map_small (.clk_i(clk_i),
        .resetn_i(resetn_i), .prog_i(prog), .req_i(req), .pc_o(pc_s), .fetch_addr_o(fa_s), .rdata_o(),
        .phase_o());

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] op, input logic [7:0] d);
        u_core_datapath_model.issue(data_req_type'{1'b1, 1'b1, op, d}, '0);
    endtask

    task automatic rdc(input logic [6:0] op, input logic [7:0] exp);
        u_core_datapath_model.issue(data_req_type'{1'b1, 1'b0, op, 8'h00}, '0);
        chk(rd, exp);
    endtask

    task automatic idle(input prog_ctl_type c);
        u_core_datapath_model.issue('0, c);
    endtask

    task automatic results;
        n_fail += u_core_datapath_model.lost;
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic t_reset;
        @(negedge clk_i);
        resetn_i = 1'b0;
        repeat (20) @(negedge clk_i);
        chk(pc, 16'h0000);
        chk(ph, phase_one);
        chk(rd, 16'h0000);
        resetn_i = 1'b1;
    endtask

    task automatic t_prog;
        wr(OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h1f);
        wr(OFS_PCL, 8'hff);
        idle('0);
        chk(pc, 16'h0000);
        wr(OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h18);
        idle(prog_ctl_type'{1'b0, 1'b1, 11'h7ff});
        chk(pc, 16'h1fff);
        chk(fa, 16'h1fff);
        chk(pc_s, 16'h1fff);
        chk(fa_s, 16'h0fff);
        // interrupt wins over a branch in the same cycle
        idle(prog_ctl_type'{1'b1, 1'b1, 11'h123});
        chk(pc, 16'h0004);
        idle('0);
    endtask

    task automatic t_banks;
        for (int b = 0; b < 4; b++) begin
            wr(OFS_STATUS, {1'b0, 2'(b), 5'h00});
            wr(GPR_START, 8'h10 + 8'(b));
        end
        for (int b = 0; b < 4; b++) begin
            wr(OFS_STATUS, {1'b0, 2'(b), 5'h00});
            rdc(GPR_START, 8'h10 + 8'(b));
        end
        wr(7'h05, 8'hff);
        rdc(7'h05, 8'h00);
        wr(7'h75, 8'h5a);
        wr(OFS_STATUS, 8'h00);
        rdc(7'h75, 8'h5a);
    endtask

    task automatic t_indirect;
        wr(OFS_STATUS, 8'h40);
        wr(OFS_POINTER, 8'h20);
        wr(OFS_STATUS, 8'h80);
        rdc(OFS_POINTER, 8'h20);
        rdc(OFS_STATUS, 8'h80);
        rdc(OFS_INDIRECT, 8'h12);
        wr(OFS_INDIRECT, 8'h77);
        wr(OFS_STATUS, 8'h40);
        rdc(GPR_START, 8'h77);
    endtask

    initial begin
        t_reset();
        t_prog();
        t_banks();
        t_indirect();
        t_reset();
        rdc(OFS_STATUS, STATUS_RESET);
        results();
    end
endmodule

`default_nettype wire
